// ### pkg/tcs_map.svh
// Summary of operation
// - On channel 0, clear codes 000 and 100 never clear the counter, and 000 is the reset value.
// - Clear code 001 clears on a general_reg_a event and 010 on a general_reg_b event, on every channel.
// - Clear code 011 (and 111 on channel 0) clears when another synchronised channel clears its own counter.
// - On channel 0, clear code 101 clears on a general_reg_c event and 110 on a general_reg_d event.
// - A general_reg_c or general_reg_d used as a buffer gives no event, so it never clears the counter.
// - A channel joins synchronous clearing only while its bit in channel_sync_register is 1.
// - On channels 1 and 2 the top clear-source bit reads 0 and ignores writes.
// - Prescale codes 000 to 011 count on the internal clock undivided, /4, /16 and /64.
// - On channel 0, prescale codes 100 to 111 count on external pins a, b, c and d.
// - On channel 1, codes 100 and 101 pick pins a and b, 110 picks /256, and software never writes 111.
// - On channel 2, codes 100 to 110 pick pins a, b and c, and 111 picks /1024.
// - A channel 1 or 2 in phase counting mode ignores its prescale selection.
// - Edge select 00 counts rising edges, 01 falling edges and 1x both edges of any count clock except the undivided one.
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// Register byte offsets
`define TCS_OFS_CTRL0   8'h00
`define TCS_OFS_CTRL1   8'h04
`define TCS_OFS_CTRL2   8'h08
`define TCS_OFS_SYNC    8'h0C
`define TCS_OFS_MODE0   8'h10
`define TCS_OFS_MODE1   8'h14
`define TCS_OFS_MODE2   8'h18
`define TCS_OFS_STATUS  8'h1C

// Control register fields
`define TCS_CLR_MSB     7
`define TCS_CLR_LSB     5
`define TCS_EDGE_MSB    4
`define TCS_EDGE_LSB    3
`define TCS_PSC_MSB     2
`define TCS_PSC_LSB     0
`define TCS_CTRL_MASK_NARROW 8'h7F

// Mode register fields and writable masks
`define TCS_MODE_BUF_A  4
`define TCS_MODE_BUF_B  5
`define TCS_MODE_PHASE  2
`define TCS_MODE_MASK0  8'h30
`define TCS_MODE_MASK12 8'h04

// Reset values
`define TCS_CTRL_RST    8'h00
`define TCS_SYNC_RST    3'h0
`define TCS_MODE_RST    8'h00

// Clear-source codes
`define TCS_CLR_NONE    3'h0
`define TCS_CLR_A       3'h1
`define TCS_CLR_B       3'h2
`define TCS_CLR_SYNC    3'h3
`define TCS_CLR_NONE2   3'h4
`define TCS_CLR_C       3'h5
`define TCS_CLR_D       3'h6
`define TCS_CLR_SYNC2   3'h7

// Prescaler: divider width and the bit whose level is each divided clock
`define TCS_DIV_W       10
`define TCS_DIV4_BIT    1
`define TCS_DIV16_BIT   3
`define TCS_DIV64_BIT   5
`define TCS_DIV256_BIT  7
`define TCS_DIV1024_BIT 9

`endif

// ### pkg/tcs_pkg.sv
`include "tcs_map.svh"

package tcs_pkg;

    // Whole state of the selector, registered as one word
    typedef struct packed {
        logic [2:0][7:0]           ctrl;
        logic [2:0][7:0]           mode;
        logic [2:0]                sync;
        logic [`TCS_DIV_W-1:0]     div;
        logic [3:0]                pin_s1;
        logic [3:0]                pin_s2;
        logic [2:0]                src_lvl;
        logic [2:0]                tick;
        logic [2:0]                clr;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
    } tcs_state_t;

endpackage : tcs_pkg

// ### core/tcs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

module tcs_top
    import tcs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output var  logic              PREADY,
    output var  logic [31:0]       PRDATA,
    output var  logic              PSLVERR,
    // Compare match or capture events from the general registers
    input  wire logic [2:0]        MATCH_A,
    input  wire logic [2:0]        MATCH_B,
    input  wire logic              MATCH_C0,
    input  wire logic              MATCH_D0,
    // External count pins
    input  wire logic              EXT_COUNT_PIN_A,
    input  wire logic              EXT_COUNT_PIN_B,
    input  wire logic              EXT_COUNT_PIN_C,
    input  wire logic              EXT_COUNT_PIN_D,
    // Strobes to the counter datapath
    output var  logic [2:0]        CLEAR_STROBE,
    output var  logic [2:0]        COUNT_TICK
);

    // The decoder reads the low eight address bits, so narrower buses fail
    if (ADDR_W < 8) begin : g_bad_addr
        $error("tcs_top: ADDR_W must be at least 8");
    end

    tcs_state_t st_ff;
    tcs_state_t nxt_st;

    // Count-clock source: {enabled, every cycle, level}
    function automatic logic [2:0] sel_src(input int ch, input logic [2:0] psc,
            input logic [`TCS_DIV_W-1:0] dv, input logic [3:0] pins);
        logic [2:0] r;
        r = 3'h0;
        case (psc)
            3'h0: r = 3'h6;
            3'h1: r = {2'h2, dv[`TCS_DIV4_BIT]};
            3'h2: r = {2'h2, dv[`TCS_DIV16_BIT]};
            3'h3: r = {2'h2, dv[`TCS_DIV64_BIT]};
            3'h4: r = {2'h2, pins[0]};
            3'h5: r = {2'h2, pins[1]};
            3'h6: begin
                if (ch == 1) begin
                    r = {2'h2, dv[`TCS_DIV256_BIT]};
                end else begin
                    r = {2'h2, pins[2]};
                end
            end
            3'h7: begin
                if (ch == 0) begin
                    r = {2'h2, pins[3]};
                end else if (ch == 2) begin
                    r = {2'h2, dv[`TCS_DIV1024_BIT]};
                end else begin
                    r = 3'h0;    // Prohibited code on channel 1
                end
            end
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // Edge detector on the selected count clock
    function automatic logic edge_hit(input logic [1:0] es, input logic prv,
            input logic cur);
        logic h;
        if (es[1]) begin
            h = prv ^ cur;
        end else if (es[0]) begin
            h = prv & ~cur;
        end else begin
            h = ~prv & cur;
        end
        return h;
    endfunction

    // Clear from the channel's own general registers
    function automatic logic own_clear(input logic [2:0] code, input logic a,
            input logic b, input logic c, input logic d, input logic buf_a,
            input logic buf_b);
        logic h;
        case (code)
            `TCS_CLR_A: h = a;
            `TCS_CLR_B: h = b;
            `TCS_CLR_C: h = c & ~buf_a;
            `TCS_CLR_D: h = d & ~buf_b;
            default:    h = 1'b0;
        endcase
        return h;
    endfunction

    // Channel-level working signals
    logic [2:0] own_clr;
    logic [2:0] src_en;
    logic [2:0] src_every;
    logic [2:0] src_lvl;
    logic [3:0] evt_c;
    logic [3:0] evt_d;
    logic [2:0] clr_code [3];
    logic       acc_done;
    logic [7:0] addr_lo;

    assign addr_lo  = PADDR[7:0];
    assign acc_done = PSEL & PENABLE & st_ff.pready;
    assign evt_c    = {3'h0, MATCH_C0};
    assign evt_d    = {3'h0, MATCH_D0};

    // Clear code per channel; narrow channels read their top bit as zero
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            clr_code[i] = st_ff.ctrl[i][`TCS_CLR_MSB:`TCS_CLR_LSB];
        end
    end

    // Source selection and own clear per channel
    always_comb begin
        logic [2:0] s;
        s = 3'h0;
        for (int i = 0; i < 3; i++) begin
            s = sel_src(i, st_ff.ctrl[i][`TCS_PSC_MSB:`TCS_PSC_LSB],
                        st_ff.div, st_ff.pin_s2);
            src_en[i]    = s[2];
            src_every[i] = s[1];
            src_lvl[i]   = s[0];
            own_clr[i] = own_clear(clr_code[i], MATCH_A[i], MATCH_B[i],
                                   evt_c[i], evt_d[i],
                                   st_ff.mode[i][`TCS_MODE_BUF_A],
                                   st_ff.mode[i][`TCS_MODE_BUF_B]);
        end
    end

    // Next-state logic: prescaler, pins, strobes and the APB slave
    always_comb begin
        logic [2:0] others;
        logic       clr_i;
        logic       tick_i;
        logic       phase;
        logic [7:0] wr;
        nxt_st = st_ff;
        others = 3'h0;
        clr_i  = 1'b0;
        tick_i = 1'b0;
        phase  = 1'b0;
        wr     = PWDATA[7:0];

        // Free-running prescaler; divided clocks are its bit levels
        nxt_st.div = st_ff.div + `TCS_DIV_W'(1);

        // Pins cross in through two flops before any logic sees them
        nxt_st.pin_s1 = {EXT_COUNT_PIN_D, EXT_COUNT_PIN_C,
                         EXT_COUNT_PIN_B, EXT_COUNT_PIN_A};
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.src_lvl = src_lvl;

        for (int i = 0; i < 3; i++) begin
            // Only synchronised channels feed and take synchronous clears
            others = own_clr & st_ff.sync & ~(3'h1 << i);
            clr_i = own_clr[i];
            if (clr_code[i][1:0] == 2'h3 && st_ff.sync[i] && |others) begin
                clr_i = 1'b1;
            end
            tick_i = src_en[i] &
                     (src_every[i] |
                      edge_hit(st_ff.ctrl[i][`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                               st_ff.src_lvl[i], src_lvl[i]));
            phase = (i != 0) && st_ff.mode[i][`TCS_MODE_PHASE];
            if (phase) begin
                tick_i = 1'b0;
            end
            nxt_st.clr[i]  = clr_i;
            nxt_st.tick[i] = tick_i & ~clr_i;
        end

        // APB answer is prepared in setup, so access finishes with no wait
        nxt_st.pready  = PSEL & ~PENABLE;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = 32'h0000_0000;
        if (PSEL && !PENABLE) begin
            case (addr_lo)
                `TCS_OFS_CTRL0:  nxt_st.prdata = {24'h0, st_ff.ctrl[0]};
                `TCS_OFS_CTRL1:  nxt_st.prdata = {24'h0, st_ff.ctrl[1]};
                `TCS_OFS_CTRL2:  nxt_st.prdata = {24'h0, st_ff.ctrl[2]};
                `TCS_OFS_SYNC:   nxt_st.prdata = {29'h0, st_ff.sync};
                `TCS_OFS_MODE0:  nxt_st.prdata = {24'h0, st_ff.mode[0]};
                `TCS_OFS_MODE1:  nxt_st.prdata = {24'h0, st_ff.mode[1]};
                `TCS_OFS_MODE2:  nxt_st.prdata = {24'h0, st_ff.mode[2]};
                `TCS_OFS_STATUS: nxt_st.prdata = {18'h0, st_ff.pin_s2,
                                                  st_ff.src_lvl, 1'b0,
                                                  st_ff.clr, st_ff.tick};
                default:         nxt_st.pslverr = 1'b1;
            endcase
            if (PADDR[ADDR_W-1:0] != ADDR_W'(addr_lo)) begin
                nxt_st.pslverr = 1'b1;
                nxt_st.prdata  = 32'h0000_0000;
            end
        end

        // A write lands only at the completing access edge
        if (acc_done && PWRITE && !st_ff.pslverr) begin
            case (addr_lo)
                `TCS_OFS_CTRL0: nxt_st.ctrl[0] = wr;
                `TCS_OFS_CTRL1: nxt_st.ctrl[1] =
                                    wr & `TCS_CTRL_MASK_NARROW;
                `TCS_OFS_CTRL2: nxt_st.ctrl[2] =
                                    wr & `TCS_CTRL_MASK_NARROW;
                `TCS_OFS_SYNC:  nxt_st.sync = wr[2:0];
                `TCS_OFS_MODE0: nxt_st.mode[0] = wr & `TCS_MODE_MASK0;
                `TCS_OFS_MODE1: nxt_st.mode[1] = wr & `TCS_MODE_MASK12;
                `TCS_OFS_MODE2: nxt_st.mode[2] = wr & `TCS_MODE_MASK12;
                default: ;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state flops
    assign PREADY       = st_ff.pready;
    assign PRDATA       = st_ff.prdata;
    assign PSLVERR      = st_ff.pslverr;
    assign CLEAR_STROBE = st_ff.clr;
    assign COUNT_TICK   = st_ff.tick;

    // Checks on the selector
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    property p_clr_disabled;
        (clr_code[0] == `TCS_CLR_NONE || clr_code[0] == `TCS_CLR_NONE2)
            |=> !CLEAR_STROBE[0];
    endproperty
    a_clr_disabled: assert property (p_clr_disabled)
        else $error("channel 0 cleared with clearing disabled");

    property p_clr_by_a;
        (clr_code[1] == `TCS_CLR_A) && MATCH_A[1] |=> CLEAR_STROBE[1];
    endproperty
    a_clr_by_a: assert property (p_clr_by_a)
        else $error("channel 1 missed clear on register a event");

    property p_clr_by_b;
        (clr_code[2] == `TCS_CLR_B) && MATCH_B[2]
            |=> CLEAR_STROBE[2];
    endproperty
    a_clr_by_b: assert property (p_clr_by_b)
        else $error("channel 2 missed clear on register b event");

    property p_sync_clear;
        (clr_code[2] == `TCS_CLR_SYNC) && st_ff.sync[2] && st_ff.sync[0]
            && (clr_code[0] == `TCS_CLR_B) && MATCH_B[0]
            |=> CLEAR_STROBE[2] && CLEAR_STROBE[0];
    endproperty
    a_sync_clear: assert property (p_sync_clear)
        else $error("synchronous clear not followed");

    property p_clr_by_c;
        (clr_code[0] == `TCS_CLR_C) && MATCH_C0
            && !st_ff.mode[0][`TCS_MODE_BUF_A] |=> CLEAR_STROBE[0];
    endproperty
    a_clr_by_c: assert property (p_clr_by_c)
        else $error("channel 0 missed clear on register c event");

    property p_buffer_no_clear;
        (clr_code[0] == `TCS_CLR_D) && st_ff.mode[0][`TCS_MODE_BUF_B]
            |=> !CLEAR_STROBE[0];
    endproperty
    a_buffer_no_clear: assert property (p_buffer_no_clear)
        else $error("buffer register caused a clear");

    property p_unsync_no_clear;
        (clr_code[1] == `TCS_CLR_SYNC) && !st_ff.sync[1] |=> !CLEAR_STROBE[1];
    endproperty
    a_unsync_no_clear: assert property (p_unsync_no_clear)
        else $error("unsynchronised channel took a sync clear");

    property p_narrow_top_bit;
        !st_ff.ctrl[1][`TCS_CLR_MSB] && !st_ff.ctrl[2][`TCS_CLR_MSB];
    endproperty
    a_narrow_top_bit: assert property (p_narrow_top_bit)
        else $error("reserved clear bit became set");

    property p_undivided;
        // The release edge still holds the strobes at zero, so skip it
        !RST && (st_ff.ctrl[0][`TCS_PSC_MSB:`TCS_PSC_LSB] == 3'h0)
            && !own_clr[0] && (clr_code[0] != `TCS_CLR_SYNC)
            && (clr_code[0] != `TCS_CLR_SYNC2) |=> COUNT_TICK[0];
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("undivided clock did not tick");

    property p_phase_ignores;
        st_ff.mode[1][`TCS_MODE_PHASE] |=> !COUNT_TICK[1];
    endproperty
    a_phase_ignores: assert property (p_phase_ignores)
        else $error("phase counting channel ticked from prescaler");

    property p_clear_wins;
        CLEAR_STROBE[2] |-> !COUNT_TICK[2];
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("tick and clear in the same cycle");

    property p_prohibited_quiet;
        (st_ff.ctrl[1][`TCS_PSC_MSB:`TCS_PSC_LSB] == 3'h7)
            ##1 (st_ff.ctrl[1][`TCS_PSC_MSB:`TCS_PSC_LSB] == 3'h7)
            |=> !COUNT_TICK[1];
    endproperty
    a_prohibited_quiet: assert property (p_prohibited_quiet)
        else $error("prohibited prescale code produced ticks");

    c_sync_clear: cover property (CLEAR_STROBE[1] && CLEAR_STROBE[0]);
    c_pin_tick:   cover property (
        st_ff.ctrl[0][`TCS_PSC_MSB:`TCS_PSC_LSB] == 3'h4 && COUNT_TICK[0]);
    c_div1024:    cover property (
        st_ff.ctrl[2][`TCS_PSC_MSB:`TCS_PSC_LSB] == 3'h7 && COUNT_TICK[2]);
    c_apb_write:  cover property (acc_done && PWRITE);

endmodule // tcs_top

`default_nettype wire

// ### dv/tcs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

module testbench
    import tcs_pkg::*;
;
    // Bench side of the ports
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [2:0]  match_a = 3'h0;
    logic [2:0]  match_b = 3'h0;
    logic        match_c = 1'b0;
    logic        match_d = 1'b0;
    logic [7:0]  pcnt    = 8'h00;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  clr;
    logic [2:0]  tick;
    // Shadow of the settings, expected-result notes and counters
    logic [7:0]  ctrl_m[3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  mode_m[3] = '{8'h00, 8'h00, 8'h00};
    logic [2:0]  sync_m    = 3'h0;
    logic [33:0] apb_q[$];
    logic [2:0]  clr_q[$];
    int          tick_cnt[3] = '{0, 0, 0};
    int          fail_count  = 0;
    int          cmp_count   = 0;
    logic [31:0] seed        = 32'h26;

    tcs_top #(.ADDR_W(8)) i_dut (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .MATCH_A(match_a),
        .MATCH_B(match_b), .MATCH_C0(match_c), .MATCH_D0(match_d),
        .EXT_COUNT_PIN_A(pcnt[2]), .EXT_COUNT_PIN_B(pcnt[3]),
        .EXT_COUNT_PIN_C(pcnt[4]), .EXT_COUNT_PIN_D(pcnt[5]),
        .CLEAR_STROBE(clr), .COUNT_TICK(tick)
    );

    // Clock, and pins toggling with periods of 8, 16, 32 and 64 cycles
    initial forever #50 clk = ~clk;
    always @(posedge clk) pcnt <= pcnt + 8'h01;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] rd_m(input logic [7:0] a);
        case (a)
            `TCS_OFS_CTRL0: return {24'h0, ctrl_m[0]};
            `TCS_OFS_CTRL1: return {24'h0, ctrl_m[1]};
            `TCS_OFS_CTRL2: return {24'h0, ctrl_m[2]};
            `TCS_OFS_SYNC:  return {29'h0, sync_m};
            `TCS_OFS_MODE0: return {24'h0, mode_m[0]};
            `TCS_OFS_MODE1: return {24'h0, mode_m[1]};
            `TCS_OFS_MODE2: return {24'h0, mode_m[2]};
            default:        return 32'h0;
        endcase
    endfunction

    // Shadow keeps only the bits that the block lets software write
    task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
        case (a)
            `TCS_OFS_CTRL0: ctrl_m[0] = d;
            `TCS_OFS_CTRL1: ctrl_m[1] = d & 8'h7F;
            `TCS_OFS_CTRL2: ctrl_m[2] = d & 8'h7F;
            `TCS_OFS_SYNC:  sync_m = d[2:0];
            `TCS_OFS_MODE0: mode_m[0] = d & `TCS_MODE_MASK0;
            `TCS_OFS_MODE1: mode_m[1] = d & `TCS_MODE_MASK12;
            `TCS_OFS_MODE2: mode_m[2] = d & `TCS_MODE_MASK12;
            default: ;
        endcase
    endtask

    // Expected strobes: own source first, then synchronous followers
    function automatic logic [2:0] exp_clr(input int ch, input int s);
        logic [2:0] own;
        logic [2:0] res;
        logic [2:0] cd;
        own = 3'h0;
        cd = ctrl_m[ch][7:5];
        own[ch] = (s == 0 && cd == 3'h1) || (s == 1 && cd == 3'h2)
            || (s == 2 && cd == 3'h5 && !mode_m[0][4])
            || (s == 3 && cd == 3'h6 && !mode_m[0][5]);
        res = own;
        for (int c = 0; c < 3; c++) begin
            cd = ctrl_m[c][7:5];
            if (sync_m[c] && (cd == 3'h3 || cd == 3'h7)
                && |(own & sync_m & ~(3'h1 << c))) res[c] = 1'b1;
        end
        return res;
    endfunction

    // One APB transfer; the note of its answer is queued first
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int   n;
        logic ok;
        ok = (a[1:0] == 2'b00) && (a <= `TCS_OFS_STATUS);
        apb_q.push_back({!wr, !ok, ok ? rd_m(a) : 32'h0});
        if (wr && ok) wr_m(a, d[7:0]);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            fail_count++;
            end_of_test();
        end
    endtask

    // One compare or capture pulse, then the strobe must have come
    task automatic fire(input int ch, input int s);
        logic [2:0] e;
        e = exp_clr(ch, s);
        if (e != 3'h0) clr_q.push_back(e);
        case (s)
            0:       match_a[ch] <= 1'b1;
            1:       match_b[ch] <= 1'b1;
            2:       match_c <= 1'b1;
            default: match_d <= 1'b1;
        endcase
        @(posedge clk);
        match_a <= 3'h0;
        match_b <= 3'h0;
        match_c <= 1'b0;
        match_d <= 1'b0;
        repeat (3) @(posedge clk);
        check(clr_q.size(), 32'h0);
    endtask

    // Tick rate over a window that is a whole number of periods
    task automatic meas(input int ch, input logic [7:0] cv, input int w,
                        input int exp);
        int t0;
        apb(1'b1, `TCS_OFS_CTRL0 + 8'(ch * 4), {24'h0, cv});
        // Settle past the source change before counting
        repeat (20) @(posedge clk);
        t0 = tick_cnt[ch];
        repeat (w) @(posedge clk);
        check(tick_cnt[ch] - t0, exp);
    endtask

    // APB answers are taken at the edge where ready is sampled high
    always @(posedge clk) begin
        logic [33:0] q;
        if (pready === 1'b1) begin
            q = (apb_q.size() > 0) ? apb_q.pop_front() : 34'h3_FFFF_FFFF;
            check({31'h0, pslverr}, {31'h0, q[32]});
            if (q[33]) check(prdata, q[31:0]);
        end
    end

    // Strobes are judged mid-cycle, where they have settled
    always @(negedge clk) begin
        logic [33:0] n;
        if (clr !== 3'h0) begin
            n = (clr_q.size() > 0) ? {31'h0, clr_q.pop_front()} : 34'h0;
            check({29'h0, clr}, n[31:0]);
            check({29'h0, clr & tick}, 32'h0);
        end
        for (int c = 0; c < 3; c++) tick_cnt[c] += int'(tick[c] === 1'b1);
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, writable masks, refused offsets
        for (int a = 0; a < 7; a++) apb(1'b0, 8'(a * 4), 32'h0);
        for (int a = 0; a < 7; a++) apb(1'b1, 8'(a * 4), 32'hFFFF_FFFF);
        for (int a = 0; a < 7; a++) apb(1'b0, 8'(a * 4), 32'h0);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b0, 8'h02, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        for (int a = 0; a < 7; a++) apb(1'b1, 8'(a * 4), 32'h0);
        $display("test registers done");
        // Every channel 0 clear code against every source
        apb(1'b1, `TCS_OFS_SYNC, 32'h7);
        apb(1'b1, `TCS_OFS_CTRL1, 32'h20);
        for (int cd = 0; cd < 8; cd++) begin
            apb(1'b1, `TCS_OFS_CTRL0, 32'(cd << 5));
            for (int s = 0; s < 4; s++) fire(0, s);
            fire(1, 0);
            fire(1, 1);
        end
        // Channel 2 follows a register b clear of channel 0, then its own
        apb(1'b1, `TCS_OFS_SYNC, 32'h5);
        apb(1'b1, `TCS_OFS_CTRL2, 32'h60);
        apb(1'b1, `TCS_OFS_CTRL0, 32'h40);
        fire(0, 1);
        apb(1'b1, `TCS_OFS_CTRL2, 32'h40);
        fire(2, 1);
        apb(1'b1, `TCS_OFS_SYNC, 32'h1);
        apb(1'b1, `TCS_OFS_CTRL0, 32'h60);
        fire(1, 0);
        apb(1'b1, `TCS_OFS_MODE0, 32'h30);
        apb(1'b1, `TCS_OFS_CTRL0, 32'hA0);
        fire(0, 2);
        apb(1'b1, `TCS_OFS_CTRL0, 32'hC0);
        fire(0, 3);
        // Random settings and events on all channels
        for (int i = 0; i < 40; i++) begin
            r = xs();
            apb(1'b1, `TCS_OFS_CTRL0, {24'h0, r[7:5], 5'h0});
            apb(1'b1, `TCS_OFS_CTRL1, {24'h0, r[10:8], 5'h0});
            apb(1'b1, `TCS_OFS_CTRL2, {24'h0, r[13:11], 5'h0});
            apb(1'b1, `TCS_OFS_SYNC, {29'h0, r[16:14]});
            apb(1'b1, `TCS_OFS_MODE0, {26'h0, r[18:17], 4'h0});
            apb(1'b0, `TCS_OFS_CTRL1, 32'h0);
            fire(r[20:19] % 3, (r[20:19] % 3 == 0) ? r[22:21] : r[21]);
        end
        $display("test clearing done");
        // Count clock sources and edges
        meas(0, 8'h00, 64, 64);
        meas(0, 8'h01, 256, 64);
        meas(0, 8'h11, 256, 128);
        meas(1, 8'h0A, 256, 16);
        meas(2, 8'h03, 256, 4);
        meas(1, 8'h06, 1024, 4);
        meas(2, 8'h07, 2048, 2);
        for (int p = 0; p < 4; p++) meas(0, 8'(4 + p), 256, 32 >> p);
        meas(1, 8'h14, 256, 64);
        meas(1, 8'h05, 256, 16);
        meas(2, 8'h0E, 256, 8);
        apb(1'b1, `TCS_OFS_MODE1, 32'h4);
        meas(1, 8'h01, 256, 0);
        apb(1'b1, `TCS_OFS_MODE2, 32'h4);
        meas(2, 8'h00, 64, 0);
        $display("test count clock done");
        repeat (5) @(posedge clk);
        check(apb_q.size(), 32'h0);
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
